// >>> core/osd_map_defines.vh
`ifndef OSD_MAP_DEFINES_VH
`define OSD_MAP_DEFINES_VH
// ==========================================================================
// Register addresses.
`define ADDR_POWER_CONTROL 8'h87
`define ADDR_UNIT_POWER_SAVE 8'hd8
`define ADDR_DAC_SYNC_CFG 8'he1
`define ADDR_ARRAY1_HIGH 8'hf3
`define ADDR_ARRAY1_LOW 8'hf4
`define ADDR_ARRAY0_HIGH 8'hf5
`define ADDR_ARRAY0_LOW 8'hf6
`define ADDR_OSD_OUT_CTRL 8'hf8
// ==========================================================================
// Reset values.
`define RST_POWER_CONTROL 8'h00
`define RST_UNIT_POWER_SAVE 8'h00
`define RST_DAC_SYNC_CFG 8'ha0
`define RST_OSD_OUT_CTRL 8'h08
// ==========================================================================
// Field positions.
`define PWR_CTRL_DOWN_BIT 6
`define PWR_CTRL_IDLE_BIT 5
`define PWR_CTRL_SLOW_BIT 4
`define SAVE_OSD_BIT 1
`define CFG_GAIN_HI 6
`define CFG_GAIN_LO 5
`define CFG_PIN_MODE_BIT 4
`define CTRL_LOAD_BIT 0
`define CTRL_OUT_EN_BIT 1
`define CTRL_CONTRAST_OFF_BIT 2
`define CTRL_BLANK_OFF_BIT 3
// ==========================================================================
// Pointer table layout.
`define PTR_CHAR_OFS 3'd0
`define PTR_PALETTE_OFS 3'd2
`define PTR_GLOBAL_OFS 3'd4
`define PTR_FONT1_OFS 3'd0
`define PTR_FONT2_OFS 3'd2
`define PTR_FONT4_OFS 3'd4
`define GLOBAL_WORD_BYTES 14'd10
`define PALETTE_BYTES 14'd96
`define CHAR_WORD_BYTES 2'd3
`define RGB_BLACK 6'h00
`endif

// >>> core/pointer_fetch.v
`timescale 1ns/1ps
// ==========================================================================
// Reads one 16-bit pointer as two XRAM bytes, low byte first.
module pointer_fetch (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire start_i,
    input wire [13:0] addr_i,
    input wire [7:0] rdata_i,
    input wire rvalid_i,
    output reg req_o,
    output reg [13:0] addr_o,
    output reg [15:0] ptr_o,
    output reg done_o
);
    localparam S_IDLE = 3'b001;
    localparam S_LOW = 3'b010;
    localparam S_HIGH = 3'b100;
    reg [2:0] state_ff;

    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_ff <= S_IDLE;
            req_o <= 1'b0;
            addr_o <= 14'h0000;
            ptr_o <= 16'h0000;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (state_ff)
                S_IDLE: begin
                    if (start_i) begin
                        req_o <= 1'b1;
                        addr_o <= addr_i;
                        state_ff <= S_LOW;
                    end
                end
                S_LOW: begin
                    if (rvalid_i) begin
                        ptr_o[7:0] <= rdata_i;
                        addr_o <= addr_o + 14'd1;
                        state_ff <= S_HIGH;
                    end
                end
                S_HIGH: begin
                    if (rvalid_i) begin
                        ptr_o[15:8] <= rdata_i;
                        req_o <= 1'b0;
                        done_o <= 1'b1;
                        state_ff <= S_IDLE;
                    end
                end
                default: begin
                    state_ff <= S_IDLE;
                    req_o <= 1'b0;
                end
            endcase
        end
    end
endmodule

// >>> core/osd_memory_map_output_control.v
`timescale 1ns/1ps
`include "osd_map_defines.vh"
module osd_memory_map_output_control (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire sfr_wr_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_addr_i,
    input wire [7:0] sfr_wdata_i,
    input wire frame_start_i,
    input wire [5:0] gen_rgb_i,
    input wire gen_blank_i,
    input wire gen_contrast_i,
    input wire [7:0] xram_rdata_i,
    input wire xram_rvalid_i,
    output reg [7:0] sfr_rdata_o,
    output reg xram_req_o,
    output reg [13:0] xram_addr_o,
    output reg [13:0] char_area_start_o,
    output reg [13:0] palette_area_start_o,
    output reg [13:0] global_word_area_start_o,
    output reg [13:0] cursor_area_start_o,
    output reg [13:0] font1_area_start_o,
    output reg [13:0] font2_area_start_o,
    output reg [13:0] font4_area_start_o,
    output reg pointers_valid_o,
    output reg global_load_o,
    output reg gen_enable_o,
    output reg [5:0] rgb_o,
    output reg [1:0] dac_gain_select_o,
    output reg dac_on_o,
    output reg fast_blank_o,
    output reg contrast_reduce_out_o
);
    // ======================================================================
    // Walk states, one-hot.
    localparam S_IDLE = 4'b0001;
    localparam S_FETCH = 4'b0010;
    localparam S_WAIT = 4'b0100;
    localparam S_LOAD = 4'b1000;

    // ======================================================================
    // Registers and internal nets.
    reg [7:0] power_control_ff;
    reg [7:0] unit_power_save_ff;
    reg [7:0] dac_and_sync_config_ff;
    reg [5:0] array1_base_high_ff;
    reg [7:0] array1_base_low_ff;
    reg [5:0] array0_base_high_ff;
    reg [7:0] array0_base_low_ff;
    reg [7:0] osd_output_control_ff;
    reg [3:0] state_ff;
    reg [2:0] ptr_idx_ff;
    reg [7:0] nxt_rdata;
    reg [13:0] ptr_addr;
    reg fetch_start_ff;
    wire osd_power_save_bit;
    wire dac_off;
    wire out_en;
    wire fetch_req;
    wire [13:0] fetch_addr;
    wire [15:0] fetch_ptr;
    wire fetch_done;
    wire [13:0] array0_base;
    wire [13:0] array1_base;

    // ======================================================================
    // Derived controls.
    // The converter is dark in display power save and in any of the low-power modes.
    assign osd_power_save_bit = unit_power_save_ff[`SAVE_OSD_BIT];
    assign dac_off = osd_power_save_bit | power_control_ff[`PWR_CTRL_DOWN_BIT] |
                     power_control_ff[`PWR_CTRL_IDLE_BIT] |
                     power_control_ff[`PWR_CTRL_SLOW_BIT];
    assign out_en = osd_output_control_ff[`CTRL_OUT_EN_BIT];
    assign array0_base = {array0_base_high_ff, array0_base_low_ff};
    assign array1_base = {array1_base_high_ff, array1_base_low_ff};

    // ======================================================================
    // Special function register writes.
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            power_control_ff <= `RST_POWER_CONTROL;
            unit_power_save_ff <= `RST_UNIT_POWER_SAVE;
            dac_and_sync_config_ff <= `RST_DAC_SYNC_CFG;
            array1_base_high_ff <= 6'h00;
            array1_base_low_ff <= 8'h00;
            array0_base_high_ff <= 6'h00;
            array0_base_low_ff <= 8'h00;
            osd_output_control_ff <= `RST_OSD_OUT_CTRL;
        end else if (sfr_wr_i) begin
            if (sfr_addr_i == `ADDR_POWER_CONTROL) begin
                power_control_ff <= sfr_wdata_i;
            end else if (sfr_addr_i == `ADDR_UNIT_POWER_SAVE) begin
                unit_power_save_ff <= sfr_wdata_i;
            end else if (sfr_addr_i == `ADDR_DAC_SYNC_CFG) begin
                dac_and_sync_config_ff <= sfr_wdata_i;
            end else if (sfr_addr_i == `ADDR_ARRAY1_HIGH) begin
                array1_base_high_ff <= sfr_wdata_i[5:0];
            end else if (sfr_addr_i == `ADDR_ARRAY1_LOW) begin
                array1_base_low_ff <= sfr_wdata_i;
            end else if (sfr_addr_i == `ADDR_ARRAY0_HIGH) begin
                array0_base_high_ff <= sfr_wdata_i[5:0];
            end else if (sfr_addr_i == `ADDR_ARRAY0_LOW) begin
                array0_base_low_ff <= sfr_wdata_i;
            end else if (sfr_addr_i == `ADDR_OSD_OUT_CTRL) begin
                // Bits 7 to 4 of the output control byte are not implemented.
                osd_output_control_ff <= {4'h0, sfr_wdata_i[3:0]};
            end
        end
    end

    // ======================================================================
    // Special function register reads.
    always @* begin
        nxt_rdata = 8'h00;
        if (sfr_addr_i == `ADDR_POWER_CONTROL) begin
            nxt_rdata = power_control_ff;
        end else if (sfr_addr_i == `ADDR_UNIT_POWER_SAVE) begin
            nxt_rdata = unit_power_save_ff;
        end else if (sfr_addr_i == `ADDR_DAC_SYNC_CFG) begin
            nxt_rdata = dac_and_sync_config_ff;
        end else if (sfr_addr_i == `ADDR_ARRAY1_HIGH) begin
            nxt_rdata = {2'b00, array1_base_high_ff};
        end else if (sfr_addr_i == `ADDR_ARRAY1_LOW) begin
            nxt_rdata = array1_base_low_ff;
        end else if (sfr_addr_i == `ADDR_ARRAY0_HIGH) begin
            nxt_rdata = {2'b00, array0_base_high_ff};
        end else if (sfr_addr_i == `ADDR_ARRAY0_LOW) begin
            nxt_rdata = array0_base_low_ff;
        end else if (sfr_addr_i == `ADDR_OSD_OUT_CTRL) begin
            // Bit 4 of the output control byte reports a completed walk.
            nxt_rdata = {3'b000, pointers_valid_o, osd_output_control_ff[3:0]};
        end
    end

    // Read data is captured on the read strobe and stands until the next read.
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_rd_i) begin
            sfr_rdata_o <= nxt_rdata;
        end
    end

    // ======================================================================
    // Pointer table walk: six pointers, indices 0..2 table one, 3..5 table two.
    always @* begin
        ptr_addr = array0_base + {11'd0, `PTR_CHAR_OFS};
        case (ptr_idx_ff)
            3'd1: ptr_addr = array0_base + {11'd0, `PTR_PALETTE_OFS};
            3'd2: ptr_addr = array0_base + {11'd0, `PTR_GLOBAL_OFS};
            3'd3: ptr_addr = array1_base + {11'd0, `PTR_FONT1_OFS};
            3'd4: ptr_addr = array1_base + {11'd0, `PTR_FONT2_OFS};
            3'd5: ptr_addr = array1_base + {11'd0, `PTR_FONT4_OFS};
            default: ptr_addr = array0_base + {11'd0, `PTR_CHAR_OFS};
        endcase
    end

    // Request and address reach the pins one register after the fetcher, so the memory
    // must take at least two cycles over each byte; a faster answer would see the old
    // address and return the low byte twice.
    pointer_fetch u_fetch (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .start_i(fetch_start_ff),
        .addr_i(ptr_addr),
        .rdata_i(xram_rdata_i),
        .rvalid_i(xram_rvalid_i),
        .req_o(fetch_req),
        .addr_o(fetch_addr),
        .ptr_o(fetch_ptr),
        .done_o(fetch_done)
    );

    // ======================================================================
    // Walk sequencer and area start registers.
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_ff <= S_IDLE;
            ptr_idx_ff <= 3'd0;
            fetch_start_ff <= 1'b0;
            xram_req_o <= 1'b0;
            xram_addr_o <= 14'h0000;
            char_area_start_o <= 14'h0000;
            palette_area_start_o <= 14'h0000;
            global_word_area_start_o <= 14'h0000;
            cursor_area_start_o <= 14'h0000;
            font1_area_start_o <= 14'h0000;
            font2_area_start_o <= 14'h0000;
            font4_area_start_o <= 14'h0000;
            pointers_valid_o <= 1'b0;
            global_load_o <= 1'b0;
        end else begin
            fetch_start_ff <= 1'b0;
            global_load_o <= 1'b0;
            // Bus requests are masked while the display unit saves power.
            xram_req_o <= fetch_req & ~osd_power_save_bit;
            xram_addr_o <= fetch_addr;
            case (state_ff)
                S_IDLE: begin
                    // A cut walk leaves the fetcher busy until requests are unmasked again;
                    // a new walk waits for it, so no stale pointer is filed.
                    if (frame_start_i && out_en && !osd_power_save_bit && !fetch_req) begin
                        ptr_idx_ff <= 3'd0;
                        fetch_start_ff <= 1'b1;
                        state_ff <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    state_ff <= S_WAIT;
                end
                S_WAIT: begin
                    // Power save abandons the walk; the next frame reads the tables afresh.
                    if (osd_power_save_bit) begin
                        state_ff <= S_IDLE;
                    end else if (fetch_done) begin
                        // Bits 15 and 14 lie beyond the 16 KB XRAM and are dropped.
                        case (ptr_idx_ff)
                            3'd0: char_area_start_o <= fetch_ptr[13:0];
                            3'd1: palette_area_start_o <= fetch_ptr[13:0];
                            3'd2: begin
                                global_word_area_start_o <= fetch_ptr[13:0];
                                cursor_area_start_o <= fetch_ptr[13:0] +
                                                       `GLOBAL_WORD_BYTES;
                            end
                            3'd3: font1_area_start_o <= fetch_ptr[13:0];
                            3'd4: font2_area_start_o <= fetch_ptr[13:0];
                            default: font4_area_start_o <= fetch_ptr[13:0];
                        endcase
                        if (ptr_idx_ff == 3'd5) begin
                            state_ff <= S_LOAD;
                        end else begin
                            ptr_idx_ff <= ptr_idx_ff + 3'd1;
                            fetch_start_ff <= 1'b1;
                            state_ff <= S_FETCH;
                        end
                    end
                end
                S_LOAD: begin
                    pointers_valid_o <= 1'b1;
                    // The global word is reloaded only while loading is allowed.
                    global_load_o <= osd_output_control_ff[`CTRL_LOAD_BIT];
                    state_ff <= S_IDLE;
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end

    // ======================================================================
    // Video output stage.
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            gen_enable_o <= 1'b0;
            rgb_o <= `RGB_BLACK;
            // The reset gain matches the reset value of the configuration register.
            dac_gain_select_o <= 2'b01;
            dac_on_o <= 1'b0;
            fast_blank_o <= 1'b1;
            contrast_reduce_out_o <= 1'b0;
        end else begin
            gen_enable_o <= out_en & ~osd_power_save_bit;
            dac_gain_select_o <= dac_and_sync_config_ff[`CFG_GAIN_HI:`CFG_GAIN_LO];
            dac_on_o <= ~dac_off;
            // Power save outranks the output enable and returns the pins to reset levels.
            if (osd_power_save_bit) begin
                rgb_o <= `RGB_BLACK;
                fast_blank_o <= 1'b1;
                contrast_reduce_out_o <= 1'b0;
            end else if (!out_en) begin
                rgb_o <= `RGB_BLACK;
                fast_blank_o <= osd_output_control_ff[`CTRL_BLANK_OFF_BIT];
                // In blank-only pin mode the contrast line stays low.
                contrast_reduce_out_o <= dac_and_sync_config_ff[`CFG_PIN_MODE_BIT] &
                                         osd_output_control_ff[`CTRL_CONTRAST_OFF_BIT];
            end else begin
                rgb_o <= dac_off ? `RGB_BLACK : gen_rgb_i;
                fast_blank_o <= gen_blank_i;
                contrast_reduce_out_o <= dac_and_sync_config_ff[`CFG_PIN_MODE_BIT] &
                                         gen_contrast_i;
            end
        end
    end
endmodule

// >>> tb/osd_map_checker_sva.sv
`timescale 1ns/1ps
// ==========================================
// Port checker that keeps a shadow of the control registers.
module osd_map_checker (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire sfr_wr_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_addr_i,
    input wire [7:0] sfr_wdata_i,
    input wire [7:0] sfr_rdata_o,
    input wire xram_req_o,
    input wire [13:0] xram_addr_o,
    input wire global_load_o,
    input wire gen_enable_o,
    input wire [5:0] rgb_o,
    input wire [1:0] dac_gain_select_o,
    input wire dac_on_o,
    input wire fast_blank_o,
    input wire contrast_reduce_out_o
);
    reg [7:0] ctl_q;
    reg [7:0] cfg_q;
    reg ps_q;
    reg pc_q;
    reg [13:0] a0_q;
    reg [13:0] a1_q;
    wire [13:0] d0 = xram_addr_o - a0_q;
    wire [13:0] d1 = xram_addr_o - a1_q;
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ctl_q <= 8'h08;
            cfg_q <= 8'ha0;
            ps_q <= 1'b0;
            pc_q <= 1'b0;
            a0_q <= 14'h0000;
            a1_q <= 14'h0000;
        end else if (sfr_wr_i) begin
            case (sfr_addr_i)
                8'h87: pc_q <= |sfr_wdata_i[6:4];
                8'hd8: ps_q <= sfr_wdata_i[1];
                8'he1: cfg_q <= sfr_wdata_i;
                8'hf3: a1_q[13:8] <= sfr_wdata_i[5:0];
                8'hf4: a1_q[7:0] <= sfr_wdata_i;
                8'hf5: a0_q[13:8] <= sfr_wdata_i[5:0];
                8'hf6: a0_q[7:0] <= sfr_wdata_i;
                8'hf8: ctl_q <= sfr_wdata_i;
                default: ;
            endcase
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    gain_cfg_a:
    assert property ($past(rst_n_i) |-> dac_gain_select_o == $past(cfg_q[6:5]))
        else $error("dac gain differs from config");
    gen_enable_a:
    assert property ($past(rst_n_i) |-> gen_enable_o == ($past(ctl_q[1]) && !$past(ps_q)))
        else $error("generator enable wrong");
    black_out_a:
    assert property (!gen_enable_o |-> rgb_o == 6'h00)
        else $error("rgb not black while disabled");
    off_level_a:
    assert property ($past(rst_n_i) && !$past(ctl_q[1]) && !$past(ps_q) |->
        fast_blank_o == $past(ctl_q[3])
        && contrast_reduce_out_o == ($past(ctl_q[2]) && $past(cfg_q[4])))
        else $error("off levels wrong");
    save_level_a:
    assert property ($past(rst_n_i) && $past(ps_q) |->
        fast_blank_o && !contrast_reduce_out_o && !dac_on_o)
        else $error("power save outputs wrong");
    dac_mode_off_a:
    assert property ($past(rst_n_i) && $past(pc_q) |-> !dac_on_o)
        else $error("dac on in low power mode");
    req_mask_a:
    assert property ($past(rst_n_i) && $past(ps_q) |-> !xram_req_o)
        else $error("request during power save");
    addr_range_a:
    assert property (xram_req_o |-> d0 < 14'd6 || d1 < 14'd6)
        else $error("fetch outside pointer tables");
    load_pulse_a:
    assert property (global_load_o |-> $past(ctl_q[0]) ##1 !global_load_o)
        else $error("global load pulse wrong");
    high_read_a:
    assert property (sfr_rd_i && sfr_addr_i == 8'hf5 |=> sfr_rdata_o == {2'b00, a0_q[13:8]})
        else $error("base high readback wrong");
    cover property (global_load_o);
    cover property (xram_req_o ##1 !xram_req_o && ps_q);
    cover property (sfr_rd_i && sfr_addr_i == 8'hf5);
endmodule
bind osd_memory_map_output_control osd_map_checker chk_u (.clk_sys_i, .rst_n_i, .sfr_wr_i,
    .sfr_rd_i, .sfr_addr_i, .sfr_wdata_i, .sfr_rdata_o, .xram_req_o, .xram_addr_o,
    .global_load_o, .gen_enable_o, .rgb_o, .dac_gain_select_o, .dac_on_o, .fast_blank_o,
    .contrast_reduce_out_o);

// >>> tb/xram_model.sv
`timescale 1ns/1ps
// ==========================================
// Internal XRAM answering byte reads after a set latency.
module xram_model (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire req_i,
    input wire [13:0] addr_i,
    input wire [3:0] lat_i,
    output reg [7:0] rdata_o,
    output reg rvalid_o,
    output reg [15:0] served_o
);
    reg [7:0] mem [0:16383];
    reg [3:0] wait_ff;
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rvalid_o <= 1'b0;
            rdata_o <= 8'h5a;
            served_o <= 16'h0000;
            wait_ff <= 4'h0;
        end else if (req_i && !rvalid_o && wait_ff >= lat_i) begin
            rvalid_o <= 1'b1;
            rdata_o <= mem[addr_i];
            served_o <= served_o + 16'h0001;
            wait_ff <= 4'h0;
        end else begin
            rvalid_o <= 1'b0;
            // Data is not held outside the valid cycle.
            rdata_o <= ~rdata_o;
            wait_ff <= req_i ? wait_ff + 4'h1 : 4'h0;
        end
    end
endmodule

// >>> tb/osd_memory_map_output_control_test.sv
`timescale 1ns/1ps
module osd_memory_map_output_control_test;
    localparam [63:0] RA = 64'h87d8e1f3f4f5f6f8;
    localparam [63:0] RV = 64'h0000a00000000008;
    localparam [95:0] PT = {16'hc456, 16'h0800, 16'h4a00,
        16'h1000, 16'h2000, 16'h3000};
    reg clk_sys_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg sfr_wr_i = 1'b0;
    reg sfr_rd_i = 1'b0;
    reg [7:0] sfr_addr_i = 8'h00;
    reg [7:0] sfr_wdata_i = 8'h00;
    reg frame_start_i = 1'b0;
    reg [5:0] gen_rgb_i = 6'h15;
    reg gen_blank_i = 1'b1;
    reg gen_contrast_i = 1'b1;
    // The block needs at least two cycles of memory latency per byte.
    reg [3:0] lat = 4'h2;
    wire [7:0] rdata, xram_rdata_i;
    wire xram_rvalid_i, req, pvalid, gload, gen_en, dac_on, blank, contrast;
    wire [13:0] xaddr, char_s, pal_s, glb_s, cur_s, f1_s, f2_s, f4_s;
    wire [15:0] served;
    wire [5:0] rgb;
    wire [1:0] gain;
    integer mismatches = 0;
    integer samples_checked = 0;
    integer loads = 0;
    integer i, k;
    osd_memory_map_output_control dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wdata_i(sfr_wdata_i), .frame_start_i(frame_start_i), .gen_rgb_i(gen_rgb_i),
        .gen_blank_i(gen_blank_i), .gen_contrast_i(gen_contrast_i),
        .xram_rdata_i(xram_rdata_i), .xram_rvalid_i(xram_rvalid_i), .sfr_rdata_o(rdata),
        .xram_req_o(req), .xram_addr_o(xaddr), .char_area_start_o(char_s),
        .palette_area_start_o(pal_s), .global_word_area_start_o(glb_s),
        .cursor_area_start_o(cur_s), .font1_area_start_o(f1_s), .font2_area_start_o(f2_s),
        .font4_area_start_o(f4_s), .pointers_valid_o(pvalid), .global_load_o(gload),
        .gen_enable_o(gen_en), .rgb_o(rgb), .dac_gain_select_o(gain), .dac_on_o(dac_on),
        .fast_blank_o(blank), .contrast_reduce_out_o(contrast));
    xram_model xram_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(req),
        .addr_i(xaddr), .lat_i(lat), .rdata_o(xram_rdata_i), .rvalid_o(xram_rvalid_i),
        .served_o(served));
    initial forever #4 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (gload === 1'b1) loads = loads + 1;
    // ==========================================
    // Bus and check tasks.
    task check(input [15:0] got, input [15:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
            if (mismatches == 0 && samples_checked > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge clk_sys_i);
            #1;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_sys_i);
            sfr_wr_i <= 1'b1;
            sfr_addr_i <= a;
            sfr_wdata_i <= d;
            @(posedge clk_sys_i);
            sfr_wr_i <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            @(posedge clk_sys_i);
            sfr_rd_i <= 1'b1;
            sfr_addr_i <= a;
            @(posedge clk_sys_i);
            sfr_rd_i <= 1'b0;
            #1 check({8'h00, rdata}, {8'h00, e});
        end
    endtask
    task frame;
        begin
            @(posedge clk_sys_i);
            frame_start_i <= 1'b1;
            @(posedge clk_sys_i);
            frame_start_i <= 1'b0;
        end
    endtask
    // Waits for the byte count to reach n, or for a request when sel is zero.
    task wait_until(input integer sel, input [15:0] n);
        integer c;
        begin
            for (c = 0; c < 400 && (sel ? served < n : req !== 1'b1); c = c + 1) tick(1);
            if (c == 400) begin
                mismatches = mismatches + 1;
                tally_and_finish;
            end
        end
    endtask
    // ==========================================
    // Test sequence.
    initial begin
        for (i = 0; i < 6; i = i + 1) begin
            k = (i < 3 ? 14'h0123 : 14'h3f00) + 2 * (i % 3);
            xram_u.mem[k] = PT[87-16*i -: 8];
            xram_u.mem[k+1] = PT[95-16*i -: 8];
        end
        repeat (6) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 8; i = i + 1) rd(RA[63-8*i -: 8], RV[63-8*i -: 8]);
        check(blank, 1'b1);
        check(contrast, 1'b0);
        rd(8'h00, 8'h00);
        wr(8'hf3, 8'hff);
        rd(8'hf3, 8'h3f);
        $display("test reset_values done");
        for (i = 0; i < 4; i = i + 1) begin
            wr(8'he1, {1'b1, i[1:0], 5'h00});
            tick(2);
            check(gain, i[1:0]);
        end
        $display("test dac_gain done");
        wr(8'he1, 8'hb0);
        for (i = 0; i < 4; i = i + 1) begin
            wr(8'hf8, {4'h0, i[1:0], 2'b00});
            tick(2);
            check(blank, i[1]);
            check(contrast, i[0]);
            check(rgb, 6'h00);
        end
        wr(8'he1, 8'ha0);
        tick(2);
        check(contrast, 1'b0);
        $display("test off_levels done");
        wr(8'hf5, 8'h01);
        wr(8'hf6, 8'h23);
        wr(8'hf3, 8'h3f);
        wr(8'hf4, 8'h00);
        rd(8'hf5, 8'h01);
        wr(8'he1, 8'hb0);
        wr(8'hf8, 8'h03);
        frame;
        wait_until(1, 16'd12);
        tick(4);
        check(char_s, 16'h0456);
        check(pal_s, 16'h0800);
        check(glb_s, 16'h0a00);
        check(cur_s, 16'h0a0a);
        check(f1_s, 16'h1000);
        check(f2_s, 16'h2000);
        check(f4_s, 16'h3000);
        check(loads, 1);
        check(pvalid, 1'b1);
        check(rgb, 6'h15);
        check({blank, contrast}, 2'b11);
        rd(8'hf8, 8'h13);
        $display("test pointer_walk done");
        lat <= 4'h5;
        wr(8'hf8, 8'h02);
        frame;
        wait_until(1, served + 16'd12);
        tick(4);
        check(loads, 1);
        $display("test load_disabled done");
        frame;
        wait_until(0, 16'd0);
        wr(8'hd8, 8'h02);
        tick(2);
        check({req, dac_on, blank, contrast, gen_en}, 5'b00100);
        frame;
        for (i = 0; i < 20; i = i + 1) begin
            tick(1);
            check(req, 1'b0);
        end
        wr(8'hd8, 8'h00);
        tick(2);
        check(dac_on, 1'b1);
        $display("test power_save done");
        for (i = 0; i < 3; i = i + 1) begin
            wr(8'h87, 8'h40 >> i);
            tick(2);
            check(dac_on, 1'b0);
            wr(8'h87, 8'h00);
            tick(2);
            check(dac_on, 1'b1);
        end
        $display("test power_modes done");
        tally_and_finish;
    end
endmodule
